// ===== core/feac_regs_consts.vh
/*
  Constants for the alarm latch, frame-bit error counter and transmit
  far-end alarm word block: register offsets, field positions, reset
  values and word layout.
  Assumes inclusion by bare name from files under core/.
*/
`ifndef FEAC_REGS_CONSTS_VH
`define FEAC_REGS_CONSTS_VH

// register offsets on the processor port
`define ADDR_W 6
`define OFS_LATCHED_STATUS 6'h17
`define OFS_FACTORY_TEST_A 6'h18
`define OFS_C3_INHIBIT 6'h19
`define OFS_FACTORY_TEST_B 6'h1A
`define OFS_FM_ERR_COUNT 6'h1B
`define OFS_ALARM_TX_WORD 6'h1C

// field positions
`define BIT_CBIT_ERROR 7
`define BIT_C3_INHIBIT 7
`define BIT_TX_GO 7
`define BIT_TX_REPEAT 6
`define TRIB_MSB 6
`define CODE_MSB 5
`define TEST_BITS_MSB 6

// reset values
`define RST_BYTE 8'h00
`define RST_TRIB 7'h00
`define RST_TEST_BITS 7'h00
`define RST_CODE 6'h00

// counter limits
`define FM_COUNT_MAX 8'hFF
`define FM_COUNT_ONE 8'h01

// alarm word layout and repetition
`define WORD_TAIL 8'hFF
`define WORD_LAST_BIT 4'hF
`define WORD_REPEATS_LAST 4'h9
`define IDX_ZERO 4'h0
`define IDX_ONE 4'h1

`endif

// ===== core/alarm_word_shifter.v
/*
  Serial sender for the 16-bit far-end alarm word, one bit per C3 slot.
  Assumes a one-cycle slot strobe from the transmit framer on core_clk,
  and a go level held by the register block for as long as it runs.
*/
`timescale 1ns/1ps
`default_nettype none
`include "feac_regs_consts.vh"

module alarm_word_shifter (
   // clock and reset
   input wire core_clk,
   input wire nrst,
   // control from the register block
   input wire start,
   input wire run,
   input wire repeat_forever,
   input wire [`CODE_MSB:0] code,
   // framer timing
   input wire c3_slot,
   // serial result
   output reg word_bit,
   output reg last_word_done
);

   reg [3:0] bit_idx;
   reg [3:0] word_cnt;
   wire [15:0] word;

   // zero, six code bits in sending order, zero, eight ones
   assign word = {1'b0, code, 1'b0, `WORD_TAIL};

   // one bit per slot, msb first; counts finished words
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         bit_idx <= `IDX_ZERO;
         word_cnt <= `IDX_ZERO;
         word_bit <= 1'b1;
         last_word_done <= 1'b0;
      end else begin
         last_word_done <= 1'b0;
         if (start) begin
            bit_idx <= `IDX_ZERO;
            word_cnt <= `IDX_ZERO;
         end else if (run && c3_slot) begin
            word_bit <= word[`WORD_LAST_BIT - bit_idx];
            bit_idx <= bit_idx + `IDX_ONE;
            if (bit_idx == `WORD_LAST_BIT) begin
               word_cnt <= word_cnt + `IDX_ONE;
               // tenth word out ends a counted message
               if (!repeat_forever && word_cnt == `WORD_REPEATS_LAST) begin
                  last_word_done <= 1'b1;
               end
            end
         end else if (!run) begin
            word_bit <= 1'b1;
         end
      end
   end

endmodule // alarm_word_shifter

`default_nettype wire

// ===== core/feac_tx_and_alarm_latch_regs.v
/*
  Latched C-bit error and tributary out-of-frame status, C3 clock
  inhibit control, saturating DS3 F/M-bit error counter and the
  transmit far-end alarm word controller of a DS3/DS1 multiplexer.
  Registers: latched status clears on read, inhibit and test storage
  are read/write, the error counter zeroes on read, and the alarm word
  register starts, stops and reports the serial sender.
  Assumes the processor port and all line-side strobes and levels are
  synchronous to core_clk, except ext_c3_data, which comes from a pin.
  Also assumes one c3_slot strobe per M-frame, never in the cycle that
  follows a start write, and a processor that stops a running word
  before it loads the next one.
*/
// Functional notes
// - latched status: bit 7 sticky C-bit error, bits 6-0 tributary out-of-frame
// - C-bit error flag sets the first time a received C1 bit is zero
// - reading the latched status register clears every set bit
// - out-of-frame still present after the clearing read sets its flag again
// - inhibit bit 7 zero adds an extra C3 clock pulse; one suppresses it
// - inhibit zero takes alarm message bits from the external C-bit interface
// - 8-bit counter of F/M-bit errors since last read, saturating
// - error counter holds while DS3 loss of signal or out-of-frame
// - reading the error counter returns its value then zeroes it
// - writing one to bit 7 starts sending; reading it shows busy
// - bit 6 one repeats forever, zero sends the word ten times
// - bits 5-0 hold the six code bits in sending order
// - each word is zero, six code bits, zero, eight ones
// - after the tenth word bit 7 clears to show completion
// - writing bits 7 and 6 zero stops a continuous transmission
`timescale 1ns/1ps
`default_nettype none
`include "feac_regs_consts.vh"

module feac_tx_and_alarm_latch_regs (
   // clock and reset
   input wire core_clk,
   input wire nrst,
   // processor port, one-cycle read and write strobes
   input wire cpu_sel,
   input wire cpu_rd,
   input wire cpu_wr,
   input wire [`ADDR_W-1:0] cpu_addr,
   input wire [7:0] cpu_wdata,
   output reg [7:0] cpu_rdata,
   // receive framer status
   input wire rx_c1_zero,
   input wire [`TRIB_MSB:0] tributary_oof,
   input wire rx_fm_bit_error,
   input wire ds3_los,
   input wire ds3_oof,
   // transmit framer and external C-bit interface
   input wire c3_slot,
   input wire ext_c3_data,
   output reg c3_tx_bit,
   output reg cbit_tx_clock_c3_pulse,
   output reg c3_clock_inhibit_out,
   output reg alarm_tx_busy
);

   // sticky status flags
   reg cbit_error_sticky;
   reg [`TRIB_MSB:0] tributary_out_of_frame_sticky;

   // control and storage
   reg c3_clock_inhibit;
   reg [`TEST_BITS_MSB:0] c3_test_bits;
   reg [7:0] factory_test_a;
   reg [7:0] factory_test_b;
   reg [7:0] frame_bit_error_count;

   // alarm word controller
   reg alarm_tx_go;
   reg alarm_tx_repeat_select;
   reg [`CODE_MSB:0] alarm_tx_code;
   reg alarm_tx_start;

   // pin synchroniser for external C3 data
   reg ext_c3_meta;
   reg ext_c3_sync;

   // next values
   reg next_cbit_error_sticky;
   reg [`TRIB_MSB:0] next_trib_sticky;
   reg [7:0] next_fm_count;
   reg next_go;
   reg [7:0] next_rdata;
   reg next_c3_tx_bit;

   wire word_bit;
   wire last_word_done;

   // address decode helper, used by reads and writes alike
   function hit;
      input [`ADDR_W-1:0] addr;
      input [`ADDR_W-1:0] ofs;
      begin
         hit = (addr == ofs);
      end
   endfunction

   wire rd_any;
   wire wr_any;
   wire rd_status;
   wire rd_count;
   wire wr_test_a;
   wire wr_inhibit;
   wire wr_test_b;
   wire wr_word;

   assign rd_any = cpu_sel & cpu_rd;
   assign wr_any = cpu_sel & cpu_wr;
   assign rd_status = rd_any & hit(cpu_addr, `OFS_LATCHED_STATUS);
   assign rd_count = rd_any & hit(cpu_addr, `OFS_FM_ERR_COUNT);
   assign wr_test_a = wr_any & hit(cpu_addr, `OFS_FACTORY_TEST_A);
   assign wr_inhibit = wr_any & hit(cpu_addr, `OFS_C3_INHIBIT);
   assign wr_test_b = wr_any & hit(cpu_addr, `OFS_FACTORY_TEST_B);
   assign wr_word = wr_any & hit(cpu_addr, `OFS_ALARM_TX_WORD);

   // alarm word write intents and counter qualifiers
   wire wr_start;
   wire wr_stop;
   wire fm_count_enable;
   wire fm_at_max;
   wire shifter_run;

   assign wr_start = wr_word & cpu_wdata[`BIT_TX_GO];
   assign wr_stop = wr_word & ~cpu_wdata[`BIT_TX_GO] & alarm_tx_repeat_select
      & ~cpu_wdata[`BIT_TX_REPEAT];
   // counting halts while the DS3 signal or its framing is lost
   assign fm_count_enable = rx_fm_bit_error & ~ds3_los & ~ds3_oof;
   assign fm_at_max = (frame_bit_error_count == `FM_COUNT_MAX);
   // the start cycle only rewinds the sender
   assign shifter_run = alarm_tx_go & ~alarm_tx_start;

   // sticky flags: read clears, a new event in the same cycle wins
   always @* begin
      next_cbit_error_sticky = cbit_error_sticky;
      next_trib_sticky = tributary_out_of_frame_sticky;
      if (rd_status) begin
         next_cbit_error_sticky = 1'b0;
         next_trib_sticky = `RST_TRIB;
      end
      if (rx_c1_zero) begin
         next_cbit_error_sticky = 1'b1;
      end
      // a level still present relatches right after the read
      next_trib_sticky = next_trib_sticky | tributary_oof;
   end

   // frame-bit error counter: saturates, holds in alarm, zeroes on read
   always @* begin
      next_fm_count = frame_bit_error_count;
      if (rd_count) begin
         next_fm_count = `RST_BYTE;
      end
      if (fm_count_enable) begin
         if (rd_count) begin
            next_fm_count = `FM_COUNT_ONE;
         end else if (!fm_at_max) begin
            next_fm_count = frame_bit_error_count + `FM_COUNT_ONE;
         end
      end
   end

   // go bit: write starts, bits 7 and 6 zero stop continuous, tenth word ends
   always @* begin
      next_go = alarm_tx_go;
      if (last_word_done) begin
         next_go = 1'b0;
      end
      if (wr_start) begin
         next_go = 1'b1;
      end else if (wr_stop) begin
         next_go = 1'b0;
      end
   end

   // read data mux; unmapped offsets read zero
   always @* begin
      next_rdata = `RST_BYTE;
      case (cpu_addr)
         `OFS_LATCHED_STATUS: begin
            next_rdata = {cbit_error_sticky, tributary_out_of_frame_sticky};
         end
         `OFS_FACTORY_TEST_A: begin
            next_rdata = factory_test_a;
         end
         `OFS_C3_INHIBIT: begin
            next_rdata = {c3_clock_inhibit, c3_test_bits};
         end
         `OFS_FACTORY_TEST_B: begin
            next_rdata = factory_test_b;
         end
         `OFS_FM_ERR_COUNT: begin
            next_rdata = frame_bit_error_count;
         end
         `OFS_ALARM_TX_WORD: begin
            next_rdata = {alarm_tx_go, alarm_tx_repeat_select, alarm_tx_code};
         end
         default: begin
            next_rdata = `RST_BYTE;
         end
      endcase
   end

   // sticky status flags
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         cbit_error_sticky <= 1'b0;
         tributary_out_of_frame_sticky <= `RST_TRIB;
      end else begin
         cbit_error_sticky <= next_cbit_error_sticky;
         tributary_out_of_frame_sticky <= next_trib_sticky;
      end
   end

   // frame-bit error counter
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         frame_bit_error_count <= `RST_BYTE;
      end else begin
         frame_bit_error_count <= next_fm_count;
      end
   end

   // processor read data, captured before the clear takes hold
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         cpu_rdata <= `RST_BYTE;
      end else if (rd_any) begin
         cpu_rdata <= next_rdata;
      end
   end

   // factory test storage; needs no write to work
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         factory_test_a <= `RST_BYTE;
         factory_test_b <= `RST_BYTE;
      end else begin
         if (wr_test_a) begin
            factory_test_a <= cpu_wdata;
         end
         if (wr_test_b) begin
            factory_test_b <= cpu_wdata;
         end
      end
   end

   // C3 clock inhibit control and its test bits
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         c3_clock_inhibit <= 1'b0;
         c3_test_bits <= `RST_TEST_BITS;
      end else begin
         if (wr_inhibit) begin
            c3_clock_inhibit <= cpu_wdata[`BIT_C3_INHIBIT];
            c3_test_bits <= cpu_wdata[`TEST_BITS_MSB:0];
         end
      end
   end

   // alarm word register; mode and code reload on every write
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         alarm_tx_go <= 1'b0;
         alarm_tx_repeat_select <= 1'b0;
         alarm_tx_code <= `RST_CODE;
         alarm_tx_start <= 1'b0;
      end else begin
         alarm_tx_go <= next_go;
         alarm_tx_start <= wr_start;
         if (wr_word) begin
            alarm_tx_repeat_select <= cpu_wdata[`BIT_TX_REPEAT];
            alarm_tx_code <= cpu_wdata[`CODE_MSB:0];
         end
      end
   end

   // two-stage synchroniser on the external C3 data pin
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         ext_c3_meta <= 1'b1;
         ext_c3_sync <= 1'b1;
      end else begin
         ext_c3_meta <= ext_c3_data;
         ext_c3_sync <= ext_c3_meta;
      end
   end

   // serial word sender; a slot in the start cycle is skipped
   alarm_word_shifter u_shifter (
      .core_clk(core_clk),
      .nrst(nrst),
      .start(alarm_tx_start),
      .run(shifter_run),
      .repeat_forever(alarm_tx_repeat_select),
      .code(alarm_tx_code),
      .c3_slot(c3_slot),
      .word_bit(word_bit),
      .last_word_done(last_word_done)
   );

   // C3 source: synced external data while inhibit is clear
   always @* begin
      next_c3_tx_bit = word_bit;
      if (!c3_clock_inhibit) begin
         next_c3_tx_bit = ext_c3_sync;
      end
   end

   // C3 bit toward the framer, idle one out of reset
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         c3_tx_bit <= 1'b1;
      end else begin
         c3_tx_bit <= next_c3_tx_bit;
      end
   end

   // extra transmit clock pulse for the C3 bit, held off by inhibit
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         cbit_tx_clock_c3_pulse <= 1'b0;
      end else begin
         cbit_tx_clock_c3_pulse <= c3_slot & ~c3_clock_inhibit;
      end
   end

   // copies of inhibit and go for the line side
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         c3_clock_inhibit_out <= 1'b0;
         alarm_tx_busy <= 1'b0;
      end else begin
         c3_clock_inhibit_out <= c3_clock_inhibit;
         alarm_tx_busy <= alarm_tx_go;
      end
   end

endmodule // feac_tx_and_alarm_latch_regs

`default_nettype wire

// ===== verif/framer_model.sv
/* Transmit framer stand-in: one C3 slot strobe per M-frame, and
   capture of the C3 bit that the block returns.
   Assumes core_clk and nrst are shared with the block. */
`timescale 1ns/1ps
`default_nettype none
module framer_model #(parameter int SLOT_PERIOD = 24) (
   // clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // framer side
   input wire logic c3_tx_bit,
   output logic c3_slot
);
   int cnt;
   logic slot_d;
   logic slot_d2;
   logic got[$];
   // slot strobe; the bit is taken two edges later, past the output flop
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         cnt <= 0;
         c3_slot <= 1'b0;
         slot_d <= 1'b0;
         slot_d2 <= 1'b0;
      end else begin
         cnt <= (cnt == SLOT_PERIOD - 1) ? 0 : cnt + 1;
         c3_slot <= (cnt == SLOT_PERIOD - 1);
         slot_d <= c3_slot;
         slot_d2 <= slot_d;
         if (slot_d2) got.push_back(c3_tx_bit);
      end
   end
endmodule // framer_model
`default_nettype wire

// ===== verif/feac_regs_sva.sv
/* Port checker for the alarm word register block.
   Assumes one clock domain and the active-low asynchronous reset. */
`timescale 1ns/1ps
`default_nettype none
module feac_regs_sva (
   // clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // processor port
   input wire logic cpu_sel,
   input wire logic cpu_rd,
   input wire logic cpu_wr,
   input wire logic [5:0] cpu_addr,
   input wire logic [7:0] cpu_wdata,
   input wire logic [7:0] cpu_rdata,
   // line side
   input wire logic c3_slot,
   input wire logic ext_c3_data,
   input wire logic c3_tx_bit,
   input wire logic cbit_tx_clock_c3_pulse,
   input wire logic c3_clock_inhibit_out,
   input wire logic alarm_tx_busy
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);
   // start writes and any write
   wire logic go_wr = cpu_sel && cpu_wr && cpu_addr == 6'h1C && cpu_wdata[7];
   wire logic any_wr = cpu_sel && cpu_wr;
   a_c3_pulse_on: assert property (c3_slot |=> cbit_tx_clock_c3_pulse == !c3_clock_inhibit_out)
      else $error("c3 pulse missing");
   a_c3_pulse_off: assert property (c3_clock_inhibit_out && $past(c3_clock_inhibit_out) |-> !cbit_tx_clock_c3_pulse)
      else $error("c3 pulse not inhibited");
   a_c3_pulse_cause: assert property (cbit_tx_clock_c3_pulse |-> $past(c3_slot))
      else $error("c3 pulse without slot");
   a_ext_data_follow: assert property ($past(nrst, 3) && !c3_clock_inhibit_out &&
      $past(!c3_clock_inhibit_out, 4) && $past(ext_c3_data, 2) == $past(ext_c3_data, 3)
      |-> c3_tx_bit == $past(ext_c3_data, 2))
      else $error("c3 bit not from external data");
   a_busy_on_start: assert property ($rose(alarm_tx_busy) |-> $past(go_wr, 2) || $past(go_wr, 3))
      else $error("busy rose without start");
   a_busy_end_cause: assert property ($fell(alarm_tx_busy) |-> $past(c3_slot, 2) || $past(c3_slot, 3) || $past(any_wr) || $past(any_wr, 2))
      else $error("busy fell without cause");
   a_idle_bit_one: assert property (c3_clock_inhibit_out && $past(c3_clock_inhibit_out, 3) && !alarm_tx_busy && !$past(alarm_tx_busy) && !$past(alarm_tx_busy, 2) |-> c3_tx_bit)
      else $error("idle c3 bit not one");
   a_rdata_hold: assert property (!$past(cpu_sel && cpu_rd) |-> $stable(cpu_rdata))
      else $error("read data changed without read");
endmodule // feac_regs_sva
bind feac_tx_and_alarm_latch_regs feac_regs_sva chk (.core_clk(core_clk), .nrst(nrst),
   .cpu_sel(cpu_sel), .cpu_rd(cpu_rd), .cpu_wr(cpu_wr), .cpu_addr(cpu_addr),
   .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .c3_slot(c3_slot), .ext_c3_data(ext_c3_data),
   .c3_tx_bit(c3_tx_bit), .cbit_tx_clock_c3_pulse(cbit_tx_clock_c3_pulse),
   .c3_clock_inhibit_out(c3_clock_inhibit_out), .alarm_tx_busy(alarm_tx_busy));
`default_nettype wire

// ===== verif/tb.sv
/* Self-checking bench for the alarm word register block, with a
   reference model of the registers. Assumes the framer model beside it. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) chk(n, e, a)
module tb;
   logic core_clk, nrst, cpu_sel, cpu_rd, cpu_wr, rx_c1_zero, rx_fm_bit_error, ds3_los, ds3_oof;
   logic ext_c3_data, c3_slot, c3_tx_bit, c3_pulse, inh_out, alarm_tx_busy, inc, rd_now;
   logic [5:0] cpu_addr;
   logic [7:0] cpu_wdata, cpu_rdata, code;
   logic [6:0] tributary_oof;
   int n_mismatch, checked, cyc, exp_rd, m_flag, m_cnt, k;
   int m_reg[64];
   feac_tx_and_alarm_latch_regs dut (.core_clk(core_clk), .nrst(nrst), .cpu_sel(cpu_sel),
      .cpu_rd(cpu_rd), .cpu_wr(cpu_wr), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
      .cpu_rdata(cpu_rdata), .rx_c1_zero(rx_c1_zero), .tributary_oof(tributary_oof),
      .rx_fm_bit_error(rx_fm_bit_error), .ds3_los(ds3_los), .ds3_oof(ds3_oof),
      .c3_slot(c3_slot), .ext_c3_data(ext_c3_data), .c3_tx_bit(c3_tx_bit),
      .cbit_tx_clock_c3_pulse(c3_pulse), .c3_clock_inhibit_out(inh_out),
      .alarm_tx_busy(alarm_tx_busy));
   framer_model fr (.core_clk(core_clk), .nrst(nrst), .c3_tx_bit(c3_tx_bit), .c3_slot(c3_slot));
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   // reference registers, updated at each edge
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         m_flag = 0;
         m_cnt = 0;
         m_reg = '{default: 0};
      end else begin
         inc = rx_fm_bit_error && !ds3_los && !ds3_oof;
         rd_now = cpu_sel && cpu_rd;
         if (rd_now) exp_rd = cpu_addr == 6'h17 ? m_flag : cpu_addr == 6'h1B ? m_cnt :
            cpu_addr == 6'h1C ? -1 : m_reg[cpu_addr];
         m_flag = (rd_now && cpu_addr == 6'h17 ? 0 : m_flag) | {rx_c1_zero, tributary_oof};
         m_cnt = (rd_now && cpu_addr == 6'h1B) ? inc : (inc && m_cnt < 255) ? m_cnt + 1 : m_cnt;
         if (cpu_sel && cpu_wr && cpu_addr inside {[6'h18:6'h1A]}) m_reg[cpu_addr] = cpu_wdata;
      end
   end
   // cycle ceiling
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 40000) begin
         n_mismatch++;
         final_report();
      end
   end
   task chk(input string n, input logic [7:0] e, input logic [7:0] a);
      checked++;
      if (e !== a) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", n, e, a);
      end
   endtask
   task bus(input logic r, input logic [5:0] a, input logic [7:0] d);
      @(negedge core_clk);
      cpu_sel = 1'b1;
      cpu_rd = r;
      cpu_wr = !r;
      cpu_addr = a;
      cpu_wdata = d;
      @(negedge core_clk);
      cpu_sel = 1'b0;
      cpu_rd = 1'b0;
      cpu_wr = 1'b0;
      if (r && exp_rd >= 0) `CHK("rdata", exp_rd[7:0], cpu_rdata);
   endtask
   task start(input logic [1:0] mode);
      code = 8'($urandom);
      do @(posedge core_clk); while (c3_slot !== 1'b1);
      bus(1'b0, 6'h1C, {mode, code[5:0]});
      repeat (3) @(negedge core_clk);
      fr.got.delete();
      `CHK("busy", 1, alarm_tx_busy);
   endtask
   task cmp_word(input int nbits);
      for (k = 0; k < nbits; k++)
         `CHK("c3 bit", (k % 16 == 0 || k % 16 == 7) ? 0 : k % 16 < 7 ? code[6 - k % 16] : 1, fr.got[k]);
   endtask
   task final_report;
      if (n_mismatch == 0 && checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      {nrst, cpu_sel, cpu_rd, cpu_wr, rx_c1_zero, rx_fm_bit_error, ds3_los, ds3_oof} = 8'h00;
      {ext_c3_data, cpu_addr, cpu_wdata, tributary_oof, n_mismatch, checked, cyc} = 0;
      void'($urandom(32'he1941db4));
      repeat (5) @(negedge core_clk);
      nrst = 1'b1;
      for (k = 0; k < 2; k++) begin
         ext_c3_data = k[0];
         repeat (6) @(negedge core_clk);
         `CHK("ext c3", k[0], c3_tx_bit);
      end
      for (int a = 23; a <= 32; a++) bus(1'b1, a[5:0], 8'h00);
      for (int a = 24; a <= 32; a++) if (a != 28) bus(1'b0, a[5:0], 8'($urandom));
      for (int a = 23; a <= 32; a++) bus(1'b1, a[5:0], 8'h00);
      for (int i = 0; i < 1500; i++) begin
         @(negedge core_clk);
         rx_c1_zero = ($urandom % 16) == 0;
         tributary_oof = ($urandom % 8 == 0) ? 7'($urandom) : 7'h00;
         rx_fm_bit_error = 1'($urandom);
         ds3_los = ($urandom % 16) == 0;
         ds3_oof = ($urandom % 16) == 0;
         if ($urandom % 8 == 0) bus(1'b1, ($urandom % 2) ? 6'h17 : 6'h1B, 8'h00);
      end
      {rx_c1_zero, ds3_los, ds3_oof, rx_fm_bit_error} = 4'h1;
      tributary_oof = 7'h55;
      repeat (300) @(negedge core_clk);
      rx_fm_bit_error = 1'b0;
      bus(1'b1, 6'h1B, 8'h00);
      bus(1'b1, 6'h17, 8'h00);
      bus(1'b1, 6'h17, 8'h00);
      bus(1'b0, 6'h19, 8'h80);
      @(negedge core_clk);
      `CHK("inhibit out", 1, inh_out);
      start(2'b10);
      for (k = 0; k < 5000 && alarm_tx_busy !== 1'b0; k++) @(negedge core_clk);
      `CHK("bits sent", 8'd160, 8'(fr.got.size()));
      cmp_word(160);
      bus(1'b1, 6'h1C, 8'h00);
      `CHK("go bit", 0, cpu_rdata[7]);
      start(2'b11);
      repeat (4080) @(negedge core_clk);
      `CHK("busy", 1, alarm_tx_busy);
      cmp_word(170);
      bus(1'b0, 6'h1C, 8'h3F);
      repeat (3) @(negedge core_clk);
      `CHK("busy", 0, alarm_tx_busy);
      final_report();
   end
endmodule // tb
`default_nettype wire
